// ===== design/dms_pkg.sv
package dms_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_PAGE   = 8'h04;
	localparam logic [7:0] OFS_CTRL   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_RDATA  = 8'h10;
	// mode register fields and reset value
	localparam int         MODE_DDR_BIT = 0;
	localparam int         MODE_DIR_BIT = 1;
	localparam logic [1:0] MODE_RST     = 2'h0;
	localparam logic [3:0] PAGE_RST     = 4'h0;
	// control fields
	localparam int CTRL_TRST_BIT = 0;
	localparam int CTRL_BPAR_BIT = 1;
	// status fields
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_DENY_BIT  = 1;
	localparam int ST_UNMAP_BIT = 2;
	localparam int ST_BOOT_BIT  = 3;
	localparam int ST_EXT_BIT   = 4;
	localparam int ST_DATA_BIT  = 5;
	// boot window in program space
	localparam logic [15:0] BOOT_LO = 16'hF800;
	localparam logic [15:0] BOOT_HI = 16'hFFFF;
	// link frame layout, first bit shifted lands in bit 0
	localparam int FRAME_BITS = 50;
	localparam int FR_WDATA   = 32;
	localparam int FR_SPACE   = 48;
	localparam int FR_WRITE   = 49;
	// extended address digits
	localparam int DIG_PAGE = 24;
	localparam int DIG_EXT  = 20;
	localparam int DIG_SPC  = 16;
	typedef enum logic [1:0] {
		DMS_IDLE = 2'b00,
		DMS_WAIT = 2'b01,
		DMS_DONE = 2'b11
	} dms_state_t;
endpackage

// ===== design/dms_mem_sel.sv
`timescale 1ns/1ps
module dms_mem_sel
	import dms_pkg::*;
(
	input  wire logic        space_data_i, // 1 data space, 0 program space
	input  wire logic [15:0] offset_i,     // 16-bit offset
	input  wire logic [1:0]  mode_i,       // mode register disable bits
	input  wire logic        boot_strap_i, // synchronised boot-window strap
	output logic             sel_int_o,    // internal memory port
	output logic             sel_ext_o     // external memory port
);
	logic in_boot;
	logic ext;

	always_comb begin
		in_boot = !space_data_i && (offset_i >= BOOT_LO) && (offset_i <= BOOT_HI);
		if (space_data_i) begin
			ext = mode_i[MODE_DDR_BIT];
		end else if (in_boot) begin
			// a set mode bit still disables internal memory inside the window
			ext = !boot_strap_i || (mode_i != MODE_RST);
		end else begin
			ext = mode_i[MODE_DIR_BIT];
		end
		sel_ext_o = ext;
		sel_int_o = !ext;
	end
endmodule

// ===== design/dms_debug_mem_top.sv
`timescale 1ns/1ps
// What this block does
// - large core: mode bits 0/1 send data/program external
// - small core uses 16-bit internal offsets
// - two program, two data memories, shared offsets
// - small core: address digit 6 carries external page
// - large core, strap on, mode zero: boot window internal
// - large core, strap off: boot window always external
// - mode register resets to zero
// - small core denies access while running
// - large core runs via emulation bus master
// - target reset clears on-chip breakpoints
module dms_debug_mem_top
	import dms_pkg::*;
#(
	parameter bit LARGE_CORE = 1'b1
)(
	input  wire logic        ref_clk_i,      // 20 MHz clock
	input  wire logic        rst_b_i,        // async reset, active low
	input  wire logic        psel_i,         // apb select
	input  wire logic        penable_i,      // apb enable
	input  wire logic        pwrite_i,       // apb direction
	input  wire logic [7:0]  paddr_i,        // apb byte address
	input  wire logic [31:0] pwdata_i,       // apb write data
	output logic      [31:0] prdata_o,       // apb read data
	output logic             pready_o,       // apb ready
	output logic             pslverr_o,      // apb error, unmapped offset
	input  wire logic        tck_i,          // test clock pin
	input  wire logic        tdi_i,          // test data in pin
	input  wire logic        tsel_i,         // frame select pin, high in frame
	output logic             tdo_o,          // test data out
	input  wire logic        iboot_i,        // boot-window strap pin
	input  wire logic        core_running_i, // core executing
	output logic             mem_req_o,      // memory request
	output logic             mem_we_o,       // memory write
	output logic             mem_ext_o,      // 1 external, 0 internal
	output logic             mem_data_o,     // 1 data, 0 program
	output logic             mem_emu_o,      // run-time emulation bus access
	output logic      [3:0]  mem_page_o,     // external page
	output logic      [15:0] mem_addr_o,     // 16-bit offset
	output logic      [15:0] mem_wdata_o,    // write data
	input  wire logic [15:0] mem_rdata_i,    // read data
	input  wire logic        mem_ack_i,      // memory done
	output logic             tgt_reset_o,    // target reset request
	output logic             bp_arm_o        // on-chip breakpoints armed
);
	logic [1:0] rst_sync;
	logic       rst_n;
	// reset release
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// pin synchronisers, third stage only for edge detection
	logic [2:0] tck_s;
	logic [2:0] tsel_s;
	logic [1:0] tdi_s;
	logic [1:0] boot_s;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tck_s  <= 3'b000;
			tsel_s <= 3'b000;
			tdi_s  <= 2'b00;
			boot_s <= 2'b00;
		end else begin
			tck_s  <= {tck_s[1:0], tck_i};
			tsel_s <= {tsel_s[1:0], tsel_i};
			tdi_s  <= {tdi_s[0], tdi_i};
			boot_s <= {boot_s[0], iboot_i};
		end
	end
	logic tck_rise, tck_fall, in_frame, frame_end;
	assign tck_rise  = tck_s[1] && !tck_s[2];
	assign tck_fall  = !tck_s[1] && tck_s[2];
	assign in_frame  = tsel_s[1];
	assign frame_end = !tsel_s[1] && tsel_s[2];

	// link shift registers
	logic [FRAME_BITS-1:0] sh, next_sh;
	logic [5:0]            cnt, next_cnt;
	logic [15:0]           osh, next_osh;
	logic                  tdo, next_tdo;
	logic [15:0]           rdata_q, next_rdata;
	logic                  frame_ok;
	always_comb begin
		next_sh  = sh;
		next_cnt = cnt;
		next_osh = osh;
		if (!in_frame) begin
			next_cnt = 6'd0;
			next_osh = rdata_q;
		end else begin
			if (tck_rise) begin
				next_sh = {tdi_s[1], sh[FRAME_BITS-1:1]};
				if (cnt != 6'd63) begin
					next_cnt = cnt + 6'd1;
				end
			end
			if (tck_fall) begin
				next_osh = {1'b0, osh[15:1]};
			end
		end
		next_tdo = next_osh[0];
	end
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sh  <= '0;
			cnt <= 6'd0;
			osh <= 16'h0000;
			tdo <= 1'b0;
		end else begin
			sh  <= next_sh;
			cnt <= next_cnt;
			osh <= next_osh;
			tdo <= next_tdo;
		end
	end
	assign tdo_o    = tdo;
	assign frame_ok = frame_end && (cnt == 6'(FRAME_BITS));

	// registers written by software
	logic [1:0] mode_q, next_mode;
	logic [3:0] page_q, next_page;
	logic       trst_q, next_trst;
	logic       bpar_q, next_bpar;
	logic       deny_q, next_deny;
	logic       unmap_q, next_unmap;
	logic [31:0] prdata, next_prdata;
	logic       perr, next_perr;
	logic       apb_wr, apb_setup, addr_ok;
	logic       set_deny, set_unmap;
	dms_state_t st, next_st;

	assign apb_setup = psel_i && !penable_i;
	assign apb_wr    = psel_i && penable_i && pwrite_i;
	assign addr_ok   = (paddr_i == OFS_MODE) || (paddr_i == OFS_PAGE) || (paddr_i == OFS_CTRL)
		|| (paddr_i == OFS_STATUS) || (paddr_i == OFS_RDATA);

	always_comb begin
		next_mode   = mode_q;
		next_page   = page_q;
		next_trst   = trst_q;
		next_bpar   = bpar_q;
		next_deny   = deny_q;
		next_unmap  = unmap_q;
		next_prdata = prdata;
		next_perr   = perr;
		if (apb_wr) begin
			case (paddr_i)
				OFS_MODE: next_mode = pwdata_i[1:0];
				OFS_PAGE: next_page = pwdata_i[3:0];
				OFS_CTRL: begin
					next_trst = pwdata_i[CTRL_TRST_BIT];
					next_bpar = pwdata_i[CTRL_BPAR_BIT];
				end
				OFS_STATUS: begin
					if (pwdata_i[ST_DENY_BIT]) next_deny = 1'b0;
					if (pwdata_i[ST_UNMAP_BIT]) next_unmap = 1'b0;
				end
				default: ;
			endcase
		end
		// hardware set wins over the write-one clear
		if (set_deny) next_deny = 1'b1;
		if (set_unmap) next_unmap = 1'b1;
		// a held target reset keeps breakpoints disarmed
		if (next_trst) next_bpar = 1'b0;
		if (apb_setup) begin
			next_perr = !addr_ok;
			case (paddr_i)
				OFS_MODE:   next_prdata = {30'h0, mode_q};
				OFS_PAGE:   next_prdata = {28'h0, page_q};
				OFS_CTRL:   next_prdata = {30'h0, bpar_q, trst_q};
				OFS_STATUS: next_prdata = {26'h0, mem_data_o, mem_ext_o, boot_s[1],
					unmap_q, deny_q, (st != DMS_IDLE)};
				OFS_RDATA:  next_prdata = {16'h0, rdata_q};
				default:    next_prdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_q  <= MODE_RST;
			page_q  <= PAGE_RST;
			trst_q  <= 1'b0;
			bpar_q  <= 1'b0;
			deny_q  <= 1'b0;
			unmap_q <= 1'b0;
			prdata  <= 32'h0000_0000;
			perr    <= 1'b0;
		end else begin
			mode_q  <= next_mode;
			page_q  <= next_page;
			trst_q  <= next_trst;
			bpar_q  <= next_bpar;
			deny_q  <= next_deny;
			unmap_q <= next_unmap;
			prdata  <= next_prdata;
			perr    <= next_perr;
		end
	end
	assign prdata_o    = prdata;
	assign pready_o    = psel_i && penable_i;
	assign pslverr_o   = psel_i && penable_i && perr;
	assign tgt_reset_o = trst_q;
	assign bp_arm_o    = bpar_q;

	// frame decode
	logic [31:0] fr_addr;
	logic        dec_data, dec_ext, dec_unmap, sel_int, sel_ext;
	logic [3:0]  dec_page;
	assign fr_addr = sh[31:0];
	dms_mem_sel u_sel (
		.space_data_i (sh[FR_SPACE]),
		.offset_i     (fr_addr[15:0]),
		.mode_i       (mode_q),
		.boot_strap_i (boot_s[1]),
		.sel_int_o    (sel_int),
		.sel_ext_o    (sel_ext)
	);
	always_comb begin
		if (LARGE_CORE) begin
			dec_data  = sh[FR_SPACE];
			dec_ext   = sel_ext && !sel_int;
			dec_page  = page_q;
			dec_unmap = 1'b0;
		end else begin
			// digit 7 is ignored, digits 5 and 4 take only their legal codes
			dec_page  = fr_addr[DIG_PAGE+:4];
			dec_ext   = fr_addr[DIG_EXT];
			dec_data  = fr_addr[DIG_SPC+1];
			dec_unmap = (fr_addr[DIG_EXT+1+:3] != 3'h0) || (fr_addr[DIG_SPC+2+:2] != 2'h0)
				|| fr_addr[DIG_SPC];
		end
	end

	// access sequencer
	logic        req, next_req, we, next_we, ext, next_ext, dat, next_dat, emu, next_emu;
	logic [3:0]  page, next_pg;
	logic [15:0] addr, next_addr, wdat, next_wdat;
	always_comb begin
		next_st    = st;
		next_req   = req;
		next_we    = we;
		next_ext   = ext;
		next_dat   = dat;
		next_emu   = emu;
		next_pg    = page;
		next_addr  = addr;
		next_wdat  = wdat;
		next_rdata = rdata_q;
		set_deny   = 1'b0;
		set_unmap  = 1'b0;
		case (st)
			DMS_IDLE: begin
				if (frame_ok) begin
					if (dec_unmap) begin
						set_unmap = 1'b1;
					end else if (core_running_i && !LARGE_CORE) begin
						set_deny = 1'b1;
					end else begin
						next_st   = DMS_WAIT;
						next_req  = 1'b1;
						next_we   = sh[FR_WRITE];
						next_ext  = dec_ext;
						next_dat  = dec_data;
						next_emu  = core_running_i;
						next_pg   = dec_page;
						next_addr = fr_addr[15:0];
						next_wdat = sh[FR_WDATA+:16];
					end
				end
			end
			DMS_WAIT: begin
				if (mem_ack_i) begin
					next_st  = DMS_DONE;
					next_req = 1'b0;
					if (!we) next_rdata = mem_rdata_i;
				end
			end
			DMS_DONE: next_st = DMS_IDLE;
			default:  next_st = DMS_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st      <= DMS_IDLE;
			req     <= 1'b0;
			we      <= 1'b0;
			ext     <= 1'b0;
			dat     <= 1'b0;
			emu     <= 1'b0;
			page    <= 4'h0;
			addr    <= 16'h0000;
			wdat    <= 16'h0000;
			rdata_q <= 16'h0000;
		end else begin
			st      <= next_st;
			req     <= next_req;
			we      <= next_we;
			ext     <= next_ext;
			dat     <= next_dat;
			emu     <= next_emu;
			page    <= next_pg;
			addr    <= next_addr;
			wdat    <= next_wdat;
			rdata_q <= next_rdata;
		end
	end
	assign mem_req_o   = req;
	assign mem_we_o    = we;
	assign mem_ext_o   = ext;
	assign mem_data_o  = dat;
	assign mem_emu_o   = emu;
	assign mem_page_o  = page;
	assign mem_addr_o  = addr;
	assign mem_wdata_o = wdat;

	sequence s_good_frame;
		frame_ok && !dec_unmap && !(core_running_i && !LARGE_CORE) && st == DMS_IDLE;
	endsequence
	sequence s_ack;
		mem_req_o && mem_ack_i;
	endsequence

	AST_MODE_RESET: assert property (@(posedge ref_clk_i) $rose(rst_n) |-> mode_q == 2'h0)
		else $error("mode register not zero after reset");
	AST_REQ_ISSUE: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		s_good_frame |=> mem_req_o && mem_addr_o == $past(fr_addr[15:0]))
		else $error("good frame did not issue request");
	AST_REQ_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("request dropped before ack");
	AST_ACK_DONE: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		s_ack ##1 1'b1 |-> !mem_req_o ##1 st == DMS_IDLE)
		else $error("sequencer did not finish after ack");
	AST_DENY: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		frame_ok && st == DMS_IDLE && !dec_unmap && core_running_i && !LARGE_CORE
		|=> deny_q && !mem_req_o)
		else $error("running small core was accessed");
	AST_UNMAP: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		frame_ok && st == DMS_IDLE && dec_unmap |=> unmap_q && !mem_req_o)
		else $error("unmapped address accessed");
	AST_BP_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		tgt_reset_o |-> !bp_arm_o)
		else $error("breakpoints armed during target reset");
	AST_DATA_EXT: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(s_good_frame and (LARGE_CORE && sh[FR_SPACE]))
		|=> mem_ext_o == $past(mode_q[0]))
		else $error("data routing ignores mode bit 0");
	AST_BOOT_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(s_good_frame and (LARGE_CORE && !sh[FR_SPACE] && fr_addr[15:0] >= BOOT_LO
		&& !boot_s[1])) |=> mem_ext_o)
		else $error("boot window internal with strap off");
	AST_BOOT_ON: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(s_good_frame and (LARGE_CORE && !sh[FR_SPACE] && fr_addr[15:0] >= BOOT_LO
		&& boot_s[1] && mode_q == 2'h0)) |=> !mem_ext_o)
		else $error("boot window external with strap on");
	AST_EMU: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(s_good_frame and (LARGE_CORE && core_running_i)) |=> mem_emu_o)
		else $error("run-time access not via emulation master");
endmodule

// ===== dv/dms_probe_model.sv
`timescale 1ns/1ps
module dms_probe_model (
	output logic      tck_o,  // test clock, low between frames
	output logic      tdi_o,  // test data to the block
	output logic      tsel_o, // frame select
	input  wire logic tdo_i   // read data back
);
	initial begin
		tck_o  = 1'b0;
		tdi_o  = 1'b0;
		tsel_o = 1'b0;
	end
	// space qualifier and all 32 address bits go out as given, no digit decode here
	task automatic send(input logic [49:0] fr, output logic [15:0] rd);
		integer i;
		#70;
		tsel_o = 1'b1;
		for (i = 0; i < 50; i++) begin
			tdi_o = fr[i];
			#100;
			if (i < 16)
				rd[i] = tdo_i;
			// half the default rate: the block's two-stage sampling must see each level
			tck_o = 1'b1;
			#200;
			tck_o = 1'b0;
			#100;
		end
		tsel_o = 1'b0;
		// released line must not keep the last bit
		tdi_o = ~tdi_o;
	endtask
endmodule

// ===== dv/dms_debug_mem_top_bench.sv
`timescale 1ns/1ps
module dms_debug_mem_top_bench;
	import dms_pkg::*;
	logic        ref_clk_i, rst_b_i, psel_i, penable_i, pwrite_i, tck_i, tdi_i, tsel_i;
	logic        iboot_i, core_running_i, mem_ack_i, tdo_o, pready_o, pslverr_o, er, haverd;
	logic        mem_req_o, mem_we_o, mem_ext_o, mem_data_o, mem_emu_o, tgt_reset_o, bp_arm_o;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [3:0]  mem_page_o;
	logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, lastrd, td;
	int          err_total, n_checks, lat;
	logic [31:0] s_prdata, srd;
	logic        s_req, s_ext;
	logic [3:0]  s_page;

	dms_debug_mem_top u_dut (.ref_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tck_i, .tdi_i, .tsel_i, .tdo_o, .iboot_i,
		.core_running_i, .mem_req_o, .mem_we_o, .mem_ext_o, .mem_data_o, .mem_emu_o,
		.mem_page_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .tgt_reset_o,
		.bp_arm_o);
	// small core variant sees the same frames and bus, decodes the address digits itself
	dms_debug_mem_top #(.LARGE_CORE(1'b0)) u_small (.ref_clk_i, .rst_b_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o(s_prdata), .pready_o(),
		.pslverr_o(), .tck_i, .tdi_i, .tsel_i, .tdo_o(), .iboot_i, .core_running_i,
		.mem_req_o(s_req), .mem_we_o(), .mem_ext_o(s_ext), .mem_data_o(), .mem_emu_o(),
		.mem_page_o(s_page), .mem_addr_o(), .mem_wdata_o(), .mem_rdata_i, .mem_ack_i,
		.tgt_reset_o(), .bp_arm_o());
	dms_probe_model u_probe (.tck_o(tck_i), .tdi_o(tdi_i), .tsel_o(tsel_i), .tdo_i(tdo_o));

	always #25 ref_clk_i = ~ref_clk_i;

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkb(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask

	// entered just after a rising edge; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		chkb("pready", 1'b1, pready_o);
		rd = prdata_o;
		srd = s_prdata;
		er = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	function automatic logic exp_ext(logic [1:0] m, logic s, logic dsp, logic [15:0] a);
		if (dsp)
			return m[0];
		if (a >= BOOT_LO && a <= BOOT_HI)
			return !(s && m == 2'b00);
		return m[1];
	endfunction

	task automatic xfer(input logic we, input logic dsp, input logic [15:0] a, input logic x,
		input logic [15:0] up, input logic sr);
		logic [15:0] rv;
		logic [15:0] wd;
		integer      n;
		rv = a ^ 16'hA5C3;
		wd = ~a;
		u_probe.send({we, dsp, wd, up, a}, td);
		if (haverd)
			chk("tdo_data", 32'(lastrd), 32'(td));
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (mem_req_o !== 1'b1 && n < 40);
		chkb("mem_req", 1'b1, mem_req_o);
		chkb("mem_ext", x, mem_ext_o);
		chkb("mem_data", dsp, mem_data_o);
		chkb("mem_we", we, mem_we_o);
		chkb("mem_emu", core_running_i, mem_emu_o);
		chk("mem_page", 32'h0000_000A, 32'(mem_page_o));
		chkb("small_req", sr, s_req);
		if (sr) begin
			chkb("small_ext", x, s_ext);
			chk("small_page", 32'h0000_0005, 32'(s_page));
		end
		chk("mem_addr", 32'(a), 32'(mem_addr_o));
		if (we)
			chk("mem_wdata", 32'(wd), 32'(mem_wdata_o));
		repeat (lat) @(posedge ref_clk_i);
		chkb("req_held", 1'b1, mem_req_o);
		mem_ack_i   <= 1'b1;
		mem_rdata_i <= rv;
		@(posedge ref_clk_i);
		mem_ack_i   <= 1'b0;
		mem_rdata_i <= ~rv;
		@(posedge ref_clk_i);
		chkb("req_done", 1'b0, mem_req_o);
		chkb("small_done", 1'b0, s_req);
		if (!we) begin
			lastrd = rv;
			haverd = 1'b1;
		end
		lat = (lat + 3) % 7;
	endtask

	initial begin
		logic [15:0] a;
		logic [15:0] up;
		logic        x;
		ref_clk_i = 1'b0;
		rst_b_i = 1'b0;
		{psel_i, penable_i, pwrite_i, iboot_i, core_running_i, mem_ack_i, haverd} = '0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0000_0000;
		mem_rdata_i = 16'h0000;
		{err_total, n_checks, lat} = '0;
		repeat (6) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		apb(1'b0, OFS_MODE, 32'h0000_0000);
		chk("mode_reset", 32'h0000_0000, rd);
		apb(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("ctrl_reset", 32'h0000_0000, rd);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chkb("unmapped_err", 1'b1, er);
		$display("test reset values done");
		apb(1'b1, OFS_PAGE, 32'h0000_000A);
		// every mode and strap setting against data, plain program and both boot edges
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 2; s++) begin
				for (int k = 0; k < 4; k++) begin
					a = (k == 3) ? BOOT_HI : (k == 2) ? BOOT_LO : 16'h1234;
					x = exp_ext(2'(m), s[0], k == 0, a);
					// digit 6 page 5, digit 5 external flag, digit 4 space code
					up = {8'h75, 3'h0, x, 2'h0, k == 0, 1'b0};
					iboot_i <= s[0];
					core_running_i <= k[0];
					apb(1'b1, OFS_MODE, 32'(m));
					xfer(k == 2, k == 0, a, x, up, !k[0]);
					apb(1'b0, OFS_STATUS, 32'h0000_0000);
					chk("status", 32'({k == 0, x, s[0], 3'h0}), rd & 32'h0000_0039);
					chk("small_status", 32'({k[0], 1'b0}), srd & 32'h0000_0006);
					apb(1'b1, OFS_STATUS, 32'h0000_0006);
				end
			end
		end
		// digit 5 of 3 is outside the small core's map, the large core ignores it
		xfer(1'b0, 1'b0, 16'h1234, exp_ext(2'h3, 1'b1, 1'b0, 16'h1234), 16'h7F3C, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("small_unmap", 32'h0000_0004, srd & 32'h0000_0006);
		$display("test memory select done");
		apb(1'b0, OFS_RDATA, 32'h0000_0000);
		chk("rdata_reg", 32'(lastrd), rd & 32'h0000_FFFF);
		$display("test read data done");
		apb(1'b1, OFS_CTRL, 32'h0000_0002);
		chkb("bp_arm_on", 1'b1, bp_arm_o);
		chkb("reset_off", 1'b0, tgt_reset_o);
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		chkb("reset_on", 1'b1, tgt_reset_o);
		chkb("bp_cleared", 1'b0, bp_arm_o);
		$display("test target control done");
		summarize();
	end

	initial begin
		#4_000_000;
		err_total++;
		$display("ERROR watchdog expected end seen hang");
		summarize();
	end
endmodule
